// *** src/deep_standby_consts.svh ***
// Constants for the deep standby mode controller: offsets, fields, resets and timing.
`ifndef DEEP_STANDBY_CONSTS_SVH
`define DEEP_STANDBY_CONSTS_SVH
// Summary of operation
// RQ1: Software clears keep bit, unlocks, sleeps deep.
// RQ2: Wake on pin reset, lowvolt, irq, wake pin.
// RQ3: Watchdog and supervisor resets never cause wake; code lets them end non-deep standby.
// RQ4: Always run both CR stabilisation waits on wake; code runs one wait of the longer, after deep standby only.
// RQ5: Regulator settling wait precedes return operations.
// RQ6: Software clears pending wake causes before entry.
// RQ7: Debug powered off during deep standby.
// RQ8: Software waits for flash algorithm completion first.
// RQ9: CPU power removed; reset cause invalid after wake.
// RQ10: Cause two invalid when cause one set.
// RQ11: Control registers keep contents in deep standby.
// RQ12: Field writes need unlock value in same write.
// RQ13: Unlock field always reads zero.
// RQ14: Reserved bits read zero, writes ignored.
// RQ15: Pin-state bit selects hold/GPIO or high impedance.
// RQ16: Mode decode from deep, standby and keep bits.
// RQ17: Products lacking deep modes keep bits zero.
// RQ18: Current field resets to 10; others prohibited.
// RQ19: Sub-oscillator register survives soft and transition resets.
// RQ20: Keep bit set only while oscillator ready.
// RQ21: Software clears both lowvolt enables to block wake; code has one enable, gating only the irq.
// RQ22: Mode entered only on core deep-sleep entry.
`define ADDR_STANDBY_MODE_CONTROL 12'h000
`define ADDR_SUBOSC_CTL 12'h004
`define ADDR_RTC_KEEP 12'h008
`define ADDR_STATUS 12'h00c
`define ADDR_WAKE_CTL 12'h010
`define UNLOCK_KEY 16'h1acc
`define STB_PIN_BIT 4
`define STB_DEEP_BIT 2
`define SUBOSC_CUR_RESET 2'h2
`define HCR_WAIT_CYCLES 16'h0040
`define LCR_WAIT_CYCLES 16'h0020
`define REG_WAIT_US 300
`define CLK_MHZ 200
`define REG_WAIT_CYCLES (`REG_WAIT_US * `CLK_MHZ)
`endif

// *** src/deep_standby_pkg.sv ***
// Types for the deep standby mode controller.
package deep_standby_pkg;
	typedef enum logic [2:0] {
		MODE_RUN,
		MODE_TIMER,
		MODE_STOP,
		MODE_RTC,
		MODE_DS_STOP,
		MODE_DS_RTC,
		MODE_BAD
	} mode_t;
	typedef enum logic [2:0] {
		ST_RUN,
		ST_STANDBY,
		ST_DEEP,
		ST_REG_WAIT,
		ST_OSC_WAIT
	} state_t;
endpackage

// *** src/wait_timer.sv ***
// Down counter that reports when a loaded wait has expired.
`timescale 1ns/1ps
`default_nettype none
module wait_timer #(
	parameter int WIDTH = 20
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic load,
	input wire logic [WIDTH-1:0] count,
	output logic done
);
	logic [WIDTH-1:0] cnt_r;
	logic busy_r;

	// Counts down from the loaded value; done pulses on the last cycle.
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			cnt_r <= '0;
			busy_r <= 1'b0;
		end else if (load) begin
			cnt_r <= count;
			busy_r <= 1'b1;
		end else if (busy_r) begin
			if (cnt_r <= WIDTH'(1)) begin
				busy_r <= 1'b0;
			end
			cnt_r <= cnt_r - WIDTH'(1);
		end
	end

	assign done = busy_r && (cnt_r <= WIDTH'(1));
endmodule
`default_nettype wire

// *** src/deep_standby_ctrl.sv ***
// Standby and deep standby mode controller with APB register slave.
`timescale 1ns/1ps
`default_nettype none
`include "deep_standby_consts.svh"
module deep_standby_ctrl #(
	parameter int REG_WAIT = `REG_WAIT_CYCLES,
	parameter int HCR_WAIT = 64,
	parameter int LCR_WAIT = 32
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic core_deep_sleep_flag,
	input wire logic sleep_entry,
	input wire logic sub_osc_ready_flag,
	input wire logic external_reset_pin,
	input wire logic lowvolt_reset,
	input wire logic lowvolt_irq,
	input wire logic lowvolt_wake_enable,
	input wire logic wake_pin,
	input wire logic watchdog_reset,
	input wire logic supervisor_reset,
	input wire logic wake_cause_one_set,
	output logic cpu_power_on,
	output logic debug_power_on,
	output logic transition_reset,
	output logic pins_hold,
	output logic pins_gpio,
	output logic pins_hiz,
	output logic hcr_osc_on,
	output logic lcr_osc_on,
	output logic regulator_low,
	output logic cause_two_valid,
	output logic reset_cause_valid,
	output logic [1:0] sub_osc_current,
	output logic mode_prohibited
);
	////////////////////////////////////////////////////////////////////////
	// Register state. No soft reset reaches these, so contents survive the
	// transition reset and the whole deep standby period.

	logic pinState_r;
	logic deepSel_r;
	logic [1:0] stbSel_r;
	logic rtcKeep_r;
	logic [1:0] subCur_r;
	logic resetCauseValid_r;
	deep_standby_pkg::state_t state_r;
	deep_standby_pkg::mode_t modeDec;
	logic wrAcc;
	logic keyOk;
	logic wakeReq;
	logic regDone;
	logic oscDone;
	logic regLoad;
	logic oscLoad;

	assign wrAcc = psel && penable && pwrite;
	assign keyOk = pwdata[31:16] == `UNLOCK_KEY;
	assign pready = 1'b1;
	assign pslverr = 1'b0;

	// Decodes the standby mode from the three select fields.
	function automatic deep_standby_pkg::mode_t decode_mode(input logic d, input logic [1:0] s, input logic k);
		case ({d, s, k})
			4'b0000: decode_mode = deep_standby_pkg::MODE_TIMER; // RQ16
			4'b0100: decode_mode = deep_standby_pkg::MODE_STOP; // RQ16
			4'b0101: decode_mode = deep_standby_pkg::MODE_RTC; // RQ16
			4'b1100: decode_mode = deep_standby_pkg::MODE_DS_STOP; // RQ16
			4'b1101: decode_mode = deep_standby_pkg::MODE_DS_RTC; // RQ16
			default: decode_mode = deep_standby_pkg::MODE_BAD;
		endcase
	endfunction

	assign modeDec = decode_mode(deepSel_r, stbSel_r, rtcKeep_r);
	assign mode_prohibited = modeDec == deep_standby_pkg::MODE_BAD;

	////////////////////////////////////////////////////////////////////////
	// Standby control register: fields change only with the unlock key.
	always_ff @(posedge clk or negedge reset_n) begin // RQ11
		if (!reset_n) begin
			pinState_r <= 1'b0;
			deepSel_r <= 1'b0;
			stbSel_r <= 2'h0;
		end else if (wrAcc && paddr == `ADDR_STANDBY_MODE_CONTROL && keyOk) begin // RQ12
			pinState_r <= pwdata[`STB_PIN_BIT];
			deepSel_r <= pwdata[`STB_DEEP_BIT];
			stbSel_r <= pwdata[1:0];
		end
	end

	// Sub-oscillator current field, reset only by the power-on reset.
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			subCur_r <= `SUBOSC_CUR_RESET; // RQ18
		end else if (wrAcc && paddr == `ADDR_SUBOSC_CTL) begin // RQ19
			subCur_r <= pwdata[2:1];
		end
	end
	assign sub_osc_current = subCur_r;

	// Keep bit: a one is accepted only while the sub oscillator is ready.
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			rtcKeep_r <= 1'b0;
		end else if (wrAcc && paddr == `ADDR_RTC_KEEP) begin
			if (!pwdata[0] || sub_osc_ready_flag) begin // RQ20
				rtcKeep_r <= pwdata[0];
			end
		end
	end

	// Read mux; unlock field and reserved bits always read zero.
	always_comb begin
		prdata = 32'h0000_0000; // RQ13 RQ14
		case (paddr)
			`ADDR_STANDBY_MODE_CONTROL: prdata = {27'h0, pinState_r, 1'b0, deepSel_r, stbSel_r}; // RQ13 RQ14
			`ADDR_SUBOSC_CTL: prdata = {29'h0, subCur_r, 1'b0}; // RQ14
			`ADDR_RTC_KEEP: prdata = {31'h0, rtcKeep_r};
			`ADDR_STATUS: prdata = {26'h0, resetCauseValid_r, cause_two_valid, 1'b0, state_r};
			default: prdata = 32'h0000_0000;
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// Power sequencer.

	// Only pin reset, lowvolt reset, enabled lowvolt irq or wake pin count.
	assign wakeReq = external_reset_pin || lowvolt_reset || (lowvolt_irq && lowvolt_wake_enable) || wake_pin; // RQ2 RQ3

	assign regLoad = state_r == deep_standby_pkg::ST_DEEP && wakeReq;
	assign oscLoad = regDone;

	wait_timer #(.WIDTH(24)) u_reg_wait (
		.clk(clk),
		.reset_n(reset_n),
		.load(regLoad),
		.count(24'(REG_WAIT)),
		.done(regDone)
	);

	wait_timer #(.WIDTH(24)) u_osc_wait (
		.clk(clk),
		.reset_n(reset_n),
		.load(oscLoad),
		.count(24'((HCR_WAIT > LCR_WAIT) ? HCR_WAIT : LCR_WAIT)),
		.done(oscDone)
	);

	// Enters the selected mode only on core deep-sleep entry.
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			state_r <= deep_standby_pkg::ST_RUN;
		end else begin
			case (state_r)
				deep_standby_pkg::ST_RUN: begin
					if (sleep_entry && core_deep_sleep_flag && !mode_prohibited) begin // RQ22
						if (deepSel_r) begin
							state_r <= deep_standby_pkg::ST_DEEP;
						end else begin
							state_r <= deep_standby_pkg::ST_STANDBY;
						end
					end
				end
				deep_standby_pkg::ST_STANDBY: begin
					if (wakeReq || watchdog_reset || supervisor_reset) begin
						state_r <= deep_standby_pkg::ST_RUN;
					end
				end
				deep_standby_pkg::ST_DEEP: begin
					if (wakeReq) begin // RQ2 RQ3
						state_r <= deep_standby_pkg::ST_REG_WAIT;
					end
				end
				deep_standby_pkg::ST_REG_WAIT: begin
					if (regDone) begin // RQ5
						state_r <= deep_standby_pkg::ST_OSC_WAIT;
					end
				end
				deep_standby_pkg::ST_OSC_WAIT: begin
					if (oscDone) begin // RQ4
						state_r <= deep_standby_pkg::ST_RUN;
					end
				end
				default: state_r <= deep_standby_pkg::ST_RUN;
			endcase
		end
	end

	// Reset cause is invalid after any deep standby episode.
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			resetCauseValid_r <= 1'b1;
		end else if (state_r == deep_standby_pkg::ST_DEEP) begin // RQ9
			resetCauseValid_r <= 1'b0;
		end
	end
	assign reset_cause_valid = resetCauseValid_r;

	logic inDeep;
	logic inStandby;
	assign inDeep = state_r != deep_standby_pkg::ST_RUN && state_r != deep_standby_pkg::ST_STANDBY;
	assign inStandby = state_r == deep_standby_pkg::ST_STANDBY;

	// Power, clock and reset outputs follow the sequencer state; cause two valid is the inverse of wake_cause_one_set.
	assign cpu_power_on = !inDeep; // RQ9
	assign debug_power_on = !inDeep; // RQ7
	assign transition_reset = inDeep; // RQ2
	assign regulator_low = state_r == deep_standby_pkg::ST_DEEP;
	assign hcr_osc_on = state_r == deep_standby_pkg::ST_OSC_WAIT || state_r == deep_standby_pkg::ST_RUN; // RQ4
	assign lcr_osc_on = hcr_osc_on; // RQ4
	assign cause_two_valid = !wake_cause_one_set; // RQ10

	// Pin state selection in standby and deep standby.
	assign pins_hiz = pinState_r && (inStandby || state_r == deep_standby_pkg::ST_DEEP); // RQ15
	assign pins_hold = !pinState_r && inStandby; // RQ15
	assign pins_gpio = !pinState_r && state_r == deep_standby_pkg::ST_DEEP; // RQ15

	////////////////////////////////////////////////////////////////////////
	// Assertions.

	sequence s_deep_wake;
		state_r == deep_standby_pkg::ST_DEEP && wakeReq;
	endsequence

	// Register bus events that the field guards react to.
	sequence s_key_write;
		wrAcc && paddr == `ADDR_STANDBY_MODE_CONTROL && keyOk;
	endsequence
	sequence s_locked_write;
		wrAcc && paddr == `ADDR_STANDBY_MODE_CONTROL && !keyOk;
	endsequence
	sequence s_keep_refused;
		wrAcc && paddr == `ADDR_RTC_KEEP && pwdata[0] && !sub_osc_ready_flag;
	endsequence

	// Sequencer steps: entry into either kind of standby and the end of the return.
	sequence s_enter_deep;
		state_r == deep_standby_pkg::ST_RUN && sleep_entry && core_deep_sleep_flag && !mode_prohibited && deepSel_r;
	endsequence
	sequence s_enter_stby;
		state_r == deep_standby_pkg::ST_RUN && sleep_entry && core_deep_sleep_flag && !mode_prohibited && !deepSel_r;
	endsequence
	sequence s_osc_expire;
		state_r == deep_standby_pkg::ST_OSC_WAIT && oscDone;
	endsequence

	AST_KEY_GUARD: assert property (@(posedge clk) disable iff (!reset_n) // RQ12
		(wrAcc && paddr == `ADDR_STANDBY_MODE_CONTROL && !keyOk) |=> $stable(stbSel_r) && $stable(deepSel_r))
		else $error("Locked write changed standby fields.");
	AST_KEY_READ: assert property (@(posedge clk) disable iff (!reset_n) // RQ13
		(paddr == `ADDR_STANDBY_MODE_CONTROL) |-> prdata[31:16] == 16'h0000)
		else $error("Unlock field read nonzero.");
	AST_RSVD_READ: assert property (@(posedge clk) disable iff (!reset_n) // RQ14
		(paddr == `ADDR_SUBOSC_CTL) |-> prdata[0] == 1'b0 && prdata[31:3] == 29'h0)
		else $error("Reserved sub-oscillator bits nonzero.");
	AST_KEEP_READY: assert property (@(posedge clk) disable iff (!reset_n) // RQ20
		$rose(rtcKeep_r) |-> $past(sub_osc_ready_flag))
		else $error("Keep bit set without oscillator ready.");
	AST_NO_WD_WAKE: assert property (@(posedge clk) disable iff (!reset_n) // RQ3
		(state_r == deep_standby_pkg::ST_DEEP && !wakeReq) |=> state_r == deep_standby_pkg::ST_DEEP)
		else $error("Deep standby left without a wake cause.");
	AST_REG_FIRST: assert property (@(posedge clk) disable iff (!reset_n) // RQ5
		s_deep_wake |=> state_r == deep_standby_pkg::ST_REG_WAIT ##1 !cpu_power_on)
		else $error("Return did not start with regulator wait.");
	AST_OSC_WAIT: assert property (@(posedge clk) disable iff (!reset_n) // RQ4
		(state_r == deep_standby_pkg::ST_REG_WAIT && regDone) |=> state_r == deep_standby_pkg::ST_OSC_WAIT && hcr_osc_on)
		else $error("Oscillator wait skipped.");
	AST_NO_ENTRY: assert property (@(posedge clk) disable iff (!reset_n) // RQ22
		(state_r == deep_standby_pkg::ST_RUN && !sleep_entry) |=> state_r == deep_standby_pkg::ST_RUN)
		else $error("Standby entered without sleep entry.");
	AST_DEBUG_OFF: assert property (@(posedge clk) disable iff (!reset_n) // RQ7
		(state_r == deep_standby_pkg::ST_DEEP) |-> !debug_power_on && !cpu_power_on)
		else $error("Debug powered in deep standby.");
	AST_SUBOSC_RST: assert property (@(posedge clk) disable iff (!reset_n) // RQ19
		(!(wrAcc && paddr == `ADDR_SUBOSC_CTL)) |=> $stable(subCur_r))
		else $error("Current field changed without write.");

	// Field writes and reads of the standby control and keep registers.
	AST_KEY_WRITE: assert property (@(posedge clk) disable iff (!reset_n) // RQ12
		s_key_write |=> stbSel_r == $past(pwdata[1:0]) && deepSel_r == $past(pwdata[`STB_DEEP_BIT]))
		else $error("Unlocked write did not reach standby fields.");
	AST_PIN_WRITE: assert property (@(posedge clk) disable iff (!reset_n) // RQ12
		s_key_write |=> pinState_r == $past(pwdata[`STB_PIN_BIT]))
		else $error("Unlocked write did not reach pin state bit.");
	AST_PIN_LOCK: assert property (@(posedge clk) disable iff (!reset_n) // RQ12
		s_locked_write |=> $stable(pinState_r))
		else $error("Locked write changed pin state bit.");
	AST_RSVD_STB: assert property (@(posedge clk) disable iff (!reset_n) // RQ14
		(paddr == `ADDR_STANDBY_MODE_CONTROL) |-> prdata[15:5] == 11'h000 && prdata[3] == 1'b0)
		else $error("Reserved standby control bits nonzero.");
	AST_KEEP_REFUSE: assert property (@(posedge clk) disable iff (!reset_n) // RQ20
		s_keep_refused |=> $stable(rtcKeep_r))
		else $error("Keep bit accepted without oscillator ready.");

	// Entry into standby only from a legal mode on deep-sleep entry, and reset cause validity.
	AST_ENTER_DEEP: assert property (@(posedge clk) disable iff (!reset_n) // RQ22
		s_enter_deep |=> state_r == deep_standby_pkg::ST_DEEP && regulator_low)
		else $error("Deep standby not entered on sleep entry.");
	AST_ENTER_STBY: assert property (@(posedge clk) disable iff (!reset_n) // RQ22
		s_enter_stby |=> state_r == deep_standby_pkg::ST_STANDBY && cpu_power_on)
		else $error("Standby not entered on sleep entry.");
	AST_NO_BAD_ENTRY: assert property (@(posedge clk) disable iff (!reset_n) // RQ16
		(state_r == deep_standby_pkg::ST_RUN && mode_prohibited) |=> state_r == deep_standby_pkg::ST_RUN)
		else $error("Prohibited mode was entered.");
	AST_CAUSE_LOST: assert property (@(posedge clk) disable iff (!reset_n) // RQ9
		(state_r == deep_standby_pkg::ST_DEEP) |=> !reset_cause_valid)
		else $error("Reset cause still valid after deep standby.");
	AST_CAUSE_TWO: assert property (@(posedge clk) disable iff (!reset_n) // RQ10
		wake_cause_one_set |-> !cause_two_valid)
		else $error("Second cause valid while first cause set.");

	// Wake causes and the return path.
	AST_WAKE_ANY: assert property (@(posedge clk) disable iff (!reset_n) // RQ2
		(state_r == deep_standby_pkg::ST_DEEP && (external_reset_pin || lowvolt_reset || wake_pin))
		|=> state_r == deep_standby_pkg::ST_REG_WAIT)
		else $error("Wake cause did not start the return.");
	AST_LV_GATE: assert property (@(posedge clk) disable iff (!reset_n) // RQ3
		(state_r == deep_standby_pkg::ST_DEEP && !lowvolt_wake_enable && !external_reset_pin && !lowvolt_reset
		&& !wake_pin) |=> state_r == deep_standby_pkg::ST_DEEP)
		else $error("Deep standby left by a disabled cause.");
	AST_REG_HOLD: assert property (@(posedge clk) disable iff (!reset_n) // RQ5
		(state_r == deep_standby_pkg::ST_REG_WAIT && !regDone) |=> state_r == deep_standby_pkg::ST_REG_WAIT)
		else $error("Regulator wait cut short.");
	AST_WAIT_DARK: assert property (@(posedge clk) disable iff (!reset_n) // RQ5
		(state_r == deep_standby_pkg::ST_REG_WAIT) |-> !cpu_power_on && !hcr_osc_on && transition_reset)
		else $error("Return began during regulator wait.");
	AST_OSC_HOLD: assert property (@(posedge clk) disable iff (!reset_n) // RQ4
		(state_r == deep_standby_pkg::ST_OSC_WAIT && !oscDone) |=> state_r == deep_standby_pkg::ST_OSC_WAIT
		&& hcr_osc_on && lcr_osc_on)
		else $error("Oscillator wait cut short.");
	AST_RETURN_RUN: assert property (@(posedge clk) disable iff (!reset_n) // RQ2
		s_osc_expire |=> state_r == deep_standby_pkg::ST_RUN && cpu_power_on && debug_power_on)
		else $error("Return did not end in run.");

	// Pin states in standby and deep standby, and register retention.
	AST_PINS_HIZ: assert property (@(posedge clk) disable iff (!reset_n) // RQ15
		(pinState_r && (inStandby || state_r == deep_standby_pkg::ST_DEEP)) |-> pins_hiz && !pins_hold && !pins_gpio)
		else $error("Pins not high impedance.");
	AST_PINS_HOLD: assert property (@(posedge clk) disable iff (!reset_n) // RQ15
		(!pinState_r && inStandby) |-> pins_hold && !pins_hiz && !pins_gpio)
		else $error("Pins not held in standby.");
	AST_PINS_GPIO: assert property (@(posedge clk) disable iff (!reset_n) // RQ15
		(!pinState_r && state_r == deep_standby_pkg::ST_DEEP) |-> pins_gpio && !pins_hiz && !pins_hold)
		else $error("Pins not general purpose in deep standby.");
	AST_REGS_KEPT: assert property (@(posedge clk) disable iff (!reset_n) // RQ11
		(inDeep && !wrAcc) |=> $stable(pinState_r) && $stable(stbSel_r) && $stable(rtcKeep_r) && $stable(subCur_r))
		else $error("Control register lost contents in deep standby.");
endmodule
`default_nettype wire

// *** bench/core_model.sv ***
// CPU core model: APB master and the deep sleep entry signals.
`timescale 1ns/1ps
`default_nettype none
module core_model (
	input wire logic clk,
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [11:0] paddr,
	output logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	output logic core_deep_sleep_flag,
	output logic sleep_entry
);
	int tmo = 0;
	// Bus idle and core awake from time zero.
	initial begin
		{psel, penable, pwrite, paddr, pwdata} = '0;
		{core_deep_sleep_flag, sleep_entry} = '0;
	end
	// One APB transfer, held until pready is seen high at a rising edge.
	task xfer(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q);
		int k;
		k = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
			k++;
		end while (pready !== 1'b1 && k < 50);
		if (k >= 50) tmo++;
		q = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask
	// Sleep is only asked for with no wake cause pending and no flash job running.
	task sleep_req(input logic go);
		core_deep_sleep_flag <= 1'b1;
		repeat (2) @(posedge clk);
		sleep_entry <= go;
		@(posedge clk);
		sleep_entry <= 1'b0;
		core_deep_sleep_flag <= 1'b0;
		repeat (2) @(posedge clk);
	endtask
endmodule
`default_nettype wire

// *** bench/tb.sv ***
// Self-checking testbench for the deep standby mode controller.
`timescale 1ns/1ps
`default_nettype none
module tb;
	localparam int RW = 20;
	logic clk = 0, reset_n = 0, oscReady = 0, lvEnable = 0, wdReset = 0, supReset = 0, causeOne = 0;
	logic psel, penable, pwrite, coreFlag, sleepEntry, pready, pslverr, cpuOn, dbgOn, trRst;
	logic pHold, pGpio, pHiz, hcrOn, lcrOn, regLow, twoValid, rstValid, prohib;
	logic [3:0] cause = '0;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, q;
	logic [1:0] subCur;
	logic deepSeen = 1'b0;
	int n_fail = 0, n_checks = 0;
	////////////////////////////////////////////////////////////////
	// Clock at 200 MHz.
	always #2.5 clk = ~clk;
	// Core model on the register bus.
	core_model cm (.clk(clk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .core_deep_sleep_flag(coreFlag), .sleep_entry(sleepEntry));
	// Design with a short regulator wait.
	deep_standby_ctrl #(.REG_WAIT(RW)) dut (.clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.core_deep_sleep_flag(coreFlag), .sleep_entry(sleepEntry), .sub_osc_ready_flag(oscReady),
		.external_reset_pin(cause[0]), .lowvolt_reset(cause[1]), .lowvolt_irq(cause[2]),
		.lowvolt_wake_enable(lvEnable), .wake_pin(cause[3]), .watchdog_reset(wdReset),
		.supervisor_reset(supReset), .wake_cause_one_set(causeOne), .cpu_power_on(cpuOn),
		.debug_power_on(dbgOn), .transition_reset(trRst), .pins_hold(pHold), .pins_gpio(pGpio),
		.pins_hiz(pHiz), .hcr_osc_on(hcrOn), .lcr_osc_on(lcrOn), .regulator_low(regLow),
		.cause_two_valid(twoValid), .reset_cause_valid(rstValid), .sub_osc_current(subCur),
		.mode_prohibited(prohib));
	////////////////////////////////////////////////////////////////
	// Compare and count.
	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
			n_fail++;
		end
	endtask
	// Read a register and compare.
	task rchk(input logic [11:0] a, input logic [31:0] exp);
		cm.xfer(1'b0, a, 32'h0, q);
		chk(q, exp);
		chk(pslverr, 1'b0);
	endtask
	// Verdict and end of run.
	task finish_test;
		n_fail += cm.tmo;
		if (n_fail == 0 && n_checks > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	// Program a mode, sleep, check the state reached, then wake by one cause.
	task run_mode(input logic [31:0] stb, input logic keep, input logic [2:0] st, input int c);
		int n;
		cm.xfer(1'b1, 12'h008, {31'h0, keep}, q);
		cm.xfer(1'b1, 12'h000, stb, q);
		chk(prohib, st == 3'h0);
		cm.sleep_req(1'b1);
		rchk(12'h00c, {26'h0, 1'b0, 1'b1, 1'b0, st} | {26'h0, !(deepSeen || st == 3'h2), 5'h0});
		if (st != 3'h0) chk({pHold, pGpio, pHiz}, stb[4] ? 3'b001 : (st == 3'h2 ? 3'b010 : 3'b100));
		if (st == 3'h2) begin
			deepSeen = 1'b1;
			chk({cpuOn, dbgOn, trRst, regLow, rstValid, hcrOn}, 6'b001100);
			wdReset <= 1'b1;
			supReset <= 1'b1;
			cause[2] <= 1'b1;
			@(posedge clk);
			{wdReset, supReset, cause[2]} <= '0;
			repeat (3) @(posedge clk);
			chk(cpuOn, 1'b0);
			lvEnable <= (c == 2);
		end
		cause[c] <= 1'b1;
		@(posedge clk);
		cause[c] <= 1'b0;
		if (st == 3'h2) begin
			n = 0;
			while (hcrOn !== 1'b1 && n < 200) begin
				@(posedge clk);
				n++;
			end
			if (n >= 200) begin
				n_fail++;
				finish_test;
			end
			chk(n >= RW && n <= RW + 4, 1'b1);
			chk({lcrOn, cpuOn}, 2'b10);
			n = 0;
			while (cpuOn !== 1'b1 && n < 200) begin
				@(posedge clk);
				n++;
			end
			if (n >= 200) begin
				n_fail++;
				finish_test;
			end
			chk(n >= 64 && n <= 68, 1'b1);
		end
		lvEnable <= 1'b0;
		repeat (2) @(posedge clk);
		cm.xfer(1'b0, 12'h00c, 32'h0, q);
		chk(q[2:0], 3'h0);
		rchk(12'h000, stb & 32'h17);
	endtask
	////////////////////////////////////////////////////////////////
	// Main sequence.
	initial begin
		repeat (5) @(posedge clk);
		reset_n <= 1'b1;
		@(posedge clk);
		rchk(12'h000, 32'h0);
		rchk(12'h004, 32'h4);
		rchk(12'h00c, 32'h30);
		cm.xfer(1'b1, 12'h000, 32'h1234_0017, q);
		rchk(12'h000, 32'h0);
		cm.xfer(1'b1, 12'h000, 32'h1acc_fffe, q);
		rchk(12'h000, 32'h16);
		cm.xfer(1'b1, 12'h004, 32'hfd, q);
		rchk(12'h004, 32'h4);
		chk(subCur, 2'h2);
		cm.xfer(1'b1, 12'h008, 32'h1, q);
		rchk(12'h008, 32'h0);
		oscReady <= 1'b1;
		cm.xfer(1'b1, 12'h008, 32'h1, q);
		rchk(12'h008, 32'h1);
		causeOne <= 1'b1;
		@(posedge clk);
		chk(twoValid, 1'b0);
		causeOne <= 1'b0;
		cm.xfer(1'b1, 12'h000, 32'h1acc_0006, q);
		cm.sleep_req(1'b0);
		rchk(12'h00c, 32'h30);
		run_mode(32'h1acc_0010, 1'b0, 3'h1, 3);
		run_mode(32'h1acc_0002, 1'b0, 3'h1, 0);
		run_mode(32'h1acc_0002, 1'b1, 3'h1, 1);
		for (int c = 0; c < 4; c++) run_mode(c[0] ? 32'h1acc_0006 : 32'h1acc_0016, c[0], 3'h2, c);
		run_mode(32'h1acc_0001, 1'b0, 3'h0, 3);
		finish_test;
	end
	// Hang guard.
	initial begin
		#100000;
		n_fail++;
		finish_test;
	end
endmodule
`default_nettype wire
